// ### pkg/cbr_pkg.sv
package cbr_pkg;

   // Byte offsets inside the 256-byte register window.
   localparam logic [7:0] OFF_RELEASE_LEVEL = 8'hf4;
   localparam logic [7:0] OFF_STRAP_CAPTURE = 8'hf6;
   localparam logic [7:0] OFF_RELOCATION = 8'hfe;
   localparam int WINDOW_OFFSET_BITS = 8;

   // Relocation register layout and reset value.
   localparam logic [15:0] RELOC_RESET = 16'h20ff;
   localparam int RELOC_SLAVE_BIT = 14;
   localparam int RELOC_MEM_BIT = 12;
   localparam int RELOC_BASE_MSB = 11;
   localparam int RELOC_IO_IGNORED_LSB = 8;
   // Bits 15 and 13 are reserved: writes leave them at their reset value.
   localparam logic [15:0] RELOC_WRITE_MASK = 16'h5fff;

   // Release level register layout.
   localparam int RELEASE_REV_LSB = 9;
   localparam int RELEASE_VARIANT_BIT = 8;

   // One register bus cycle from the core bus controller.
   typedef struct packed {
      logic valid;
      logic write;
      logic mem_space;
      logic [19:0] addr;
      logic [15:0] wdata;
   } cbr_bus_req_t;

   // Answer, one cycle after the cycle was taken.
   typedef struct packed {
      logic window_hit;
      logic ack;
      logic unmapped;
      logic [15:0] rdata;
   } cbr_bus_rsp_t;

endpackage

// ### src/cbr_window_decode.sv
`timescale 1ns/10ps
module cbr_window_decode (
   // Bus cycle and current relocation value
   input wire cbr_pkg::cbr_bus_req_t req,
   input wire logic [15:0] relocation,
   // Decode results
   output logic in_window,
   output logic sel_release,
   output logic sel_straps,
   output logic sel_reloc,
   output logic unmapped
);

   wire logic window_mem = relocation[cbr_pkg::RELOC_MEM_BIT];
   wire logic [11:0] base_upper = relocation[cbr_pkg::RELOC_BASE_MSB:0];
   wire logic [7:0] offset = req.addr[cbr_pkg::WINDOW_OFFSET_BITS-1:0];

   // I/O addresses are sixteen bits wide, so the top four base bits take no part there.
   wire logic mem_match = req.addr[19:8] == base_upper;
   wire logic io_match = req.addr[15:8] == base_upper[7:0];
   wire logic space_ok = req.mem_space == window_mem;
   wire logic addr_ok = window_mem ? mem_match : io_match;

   assign in_window = req.valid & space_ok & addr_ok;
   assign sel_release = in_window & (offset == cbr_pkg::OFF_RELEASE_LEVEL);
   assign sel_straps = in_window & (offset == cbr_pkg::OFF_STRAP_CAPTURE);
   assign sel_reloc = in_window & (offset == cbr_pkg::OFF_RELOCATION);
   assign unmapped = in_window & ~(sel_release | sel_straps | sel_reloc);

endmodule

// ### src/cbr_strap_capture.sv
`timescale 1ns/10ps
module cbr_strap_capture #(
   parameter bit NARROW_BUS = 1'b0
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Pins sampled during reset
   input wire logic [15:0] muxed_bus_lines_in,
   input wire logic [7:0] upper_address_outputs_in,
   // Results
   output logic in_reset,
   output logic [15:0] captured_straps
);

   logic [15:0] pin_meta;
   logic [15:0] pin_sync;

   // The narrow variant carries the upper byte on its upper address outputs.
   wire logic [15:0] pin_view = NARROW_BUS ?
      {upper_address_outputs_in, muxed_bus_lines_in[7:0]} : muxed_bus_lines_in;

   // Data path only: no reset, so the pin levels never meet the asynchronous reset.
   always_ff @(posedge core_clk)
   begin
      pin_meta <= pin_view;
      pin_sync <= pin_meta;
   end

   // Set at once by reset, cleared on the first edge after its release.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         in_reset <= 1'b1;
      else
         in_reset <= 1'b0;
   end

   // Keeps tracking the strap levels throughout reset and freezes at release.
   always_ff @(posedge core_clk)
   begin
      if (in_reset)
         captured_straps <= pin_sync;
   end

endmodule

// ### src/cbr_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// R01: Relocation register is sixteen bits wide at window offset FEh.
// R02: Reset loads relocation with 20FFh: window at FF00h, I/O space, master.
// R03: Relocation bit 14 set means interrupt controller slave, clear means master.
// R04: Relocation bit 12 set places window in memory, clear in I/O space.
// R05: Relocation bits 11..0 give base address bits 19..8; low byte is zero.
// R06: In I/O space the top four base bits are ignored by the decoder.
// R07: Software must program the top four base bits zero for I/O space.
// R08: Overlapping chip selects need zero wait states and ignored ready.
// R09: The 256-byte window decodes as an internal chip-select range.
// R10: Offsets in the window without a register here answer as unimplemented.
// R11: During reset the bus line levels are caught into strap capture, F6h.
// R12: Lines map bit for bit; narrow variant takes 15..8 from upper outputs.
// R13: After reset release the captured value holds and is readable.
// R14: Strap capture is read-only and valid until the next reset.
// R15: The multiplexed bus lines stay undriven throughout reset.
// R16: Outside logic presents straps by weak pulls or a reset-only driver.
// R17: Release level at F4h is read-only; bits 15..9 carry the revision.
// R18: Release bit 8 is zero on the wide variant, one on the narrow.
// R19: Writes to reserved relocation bits are ignored; release low byte reads zero.
module cbr_top #(
   parameter bit NARROW_BUS = 1'b0,
   // Arbitrary revision value; the real one is set per release.
   parameter logic [6:0] RELEASE_REV = 7'h01
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register bus from the core bus controller
   input wire cbr_pkg::cbr_bus_req_t bus_req,
   output cbr_pkg::cbr_bus_rsp_t bus_rsp,
   // Multiplexed bus pins
   input wire logic [15:0] muxed_bus_lines_in,
   input wire logic [7:0] upper_address_outputs_in,
   output logic [15:0] muxed_bus_lines_out,
   output logic muxed_bus_lines_oe,
   // Pin drive request from the core
   input wire logic [15:0] core_ad_out,
   input wire logic core_ad_oe,
   // Configuration to the rest of the chip
   output logic intc_slave_mode,
   output logic window_in_memory,
   output logic [19:0] window_base,
   output logic [15:0] captured_straps
);

   // Parameter checks at elaboration.
   if (RELEASE_REV == 7'h00)
   begin : g_rev_check
      $error("Release revision zero is reserved for no silicon.");
   end

   // Stored relocation value; reserved bits hold their reset value.
   logic [15:0] relocation;
   logic [15:0] next_relocation;

   // Registered answer to the bus controller.
   cbr_pkg::cbr_bus_rsp_t next_bus_rsp;

   // Reset state from the strap capture block.
   logic in_reset;

   // Decode results for the current bus cycle.
   logic in_window;
   logic sel_release;
   logic sel_straps;
   logic sel_reloc;
   logic unmapped;

   // Pin drive next values.
   logic [15:0] next_lines_out;
   logic next_lines_oe;

   // Fixed content of the release level register.
   wire logic [15:0] release_word = {
      RELEASE_REV,
      NARROW_BUS,
      8'h00
   };

   // Reserved bits are never written, so a read straight after reset returns
   // the full reset word and software cannot park values in them.
   function automatic logic [15:0] reloc_merge(input logic [15:0] old_value, input logic [15:0] new_value);
      reloc_merge = (new_value & cbr_pkg::RELOC_WRITE_MASK) | (old_value & ~cbr_pkg::RELOC_WRITE_MASK);
   endfunction

   // Window base as a 20-bit address; the low byte is always zero.
   function automatic logic [19:0] base_of(input logic [15:0] value);
      logic [19:0] base;
      base = {value[cbr_pkg::RELOC_BASE_MSB:0], 8'h00};
      base_of = base;
   endfunction

   cbr_window_decode u_decode (
      .req(bus_req),
      .relocation(relocation),
      .in_window(in_window),
      .sel_release(sel_release),
      .sel_straps(sel_straps),
      .sel_reloc(sel_reloc),
      .unmapped(unmapped)
   ); // R06 R09

   cbr_strap_capture #(
      .NARROW_BUS(NARROW_BUS)
   ) u_straps (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .muxed_bus_lines_in(muxed_bus_lines_in),
      .upper_address_outputs_in(upper_address_outputs_in),
      .in_reset(in_reset),
      .captured_straps(captured_straps)
   ); // R11 R12 R13

   // Write side.
   wire logic bus_write = bus_req.valid & bus_req.write;
   // Writes to the release level and strap capture reach no storage at all.
   wire logic reloc_we = bus_write & sel_reloc; // R01 R14

   assign next_relocation = reloc_we ?
      reloc_merge(relocation, bus_req.wdata) : relocation; // R19

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         relocation <= cbr_pkg::RELOC_RESET; // R02
      else
         relocation <= next_relocation;
   end

   // Read side.
   wire logic bus_read = bus_req.valid & ~bus_req.write;
   wire logic [15:0] read_word =
      sel_reloc ? relocation :
      sel_straps ? captured_straps : // R13
      sel_release ? release_word : // R17 R18
      16'h0000; // R10

   // Answer: window_hit says the cycle was internal, so ready is ignored.
   always_comb
   begin
      next_bus_rsp = '0;
      next_bus_rsp.window_hit = in_window; // R08 R09
      next_bus_rsp.ack = sel_reloc | sel_straps | sel_release;
      next_bus_rsp.unmapped = unmapped; // R10
      next_bus_rsp.rdata = bus_read ? read_word : 16'h0000;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         bus_rsp <= '0;
      else
         bus_rsp <= next_bus_rsp;
   end

   // Configuration outputs follow the stored relocation value.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         intc_slave_mode <= cbr_pkg::RELOC_RESET[cbr_pkg::RELOC_SLAVE_BIT];
         window_in_memory <= cbr_pkg::RELOC_RESET[cbr_pkg::RELOC_MEM_BIT];
         window_base <= base_of(cbr_pkg::RELOC_RESET);
      end
      else
      begin
         intc_slave_mode <= next_relocation[cbr_pkg::RELOC_SLAVE_BIT]; // R03
         window_in_memory <= next_relocation[cbr_pkg::RELOC_MEM_BIT]; // R04
         window_base <= base_of(next_relocation); // R05
      end
   end

   // Pin drive: the bus lines stay released while reset is in force, so the
   // strap levels on them are never fought; a driver that switched on too
   // early would overwrite the configuration just being captured.
   assign next_lines_oe = core_ad_oe & ~in_reset; // R15
   assign next_lines_out = next_lines_oe ? core_ad_out : 16'h0000;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         muxed_bus_lines_oe <= 1'b0; // R15
         muxed_bus_lines_out <= 16'h0000;
      end
      else
      begin
         muxed_bus_lines_oe <= next_lines_oe;
         muxed_bus_lines_out <= next_lines_out;
      end
   end

endmodule

// ### sim/cbr_top_properties.sv
`timescale 1ns/10ps
module cbr_top_checker #(
   parameter bit NARROW_BUS = 1'b0,
   parameter logic [6:0] RELEASE_REV = 7'h01
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register bus
   input wire cbr_pkg::cbr_bus_req_t bus_req,
   input wire cbr_pkg::cbr_bus_rsp_t bus_rsp,
   // Pins and configuration
   input wire logic muxed_bus_lines_oe,
   input wire logic intc_slave_mode,
   input wire logic window_in_memory,
   input wire logic [19:0] window_base,
   input wire logic [15:0] captured_straps
);
   wire [7:0] off = bus_req.addr[7:0];
   wire known = off == 8'hf4 || off == 8'hf6 || off == 8'hfe;
   // I/O cycles compare only address bits 15..8, so the top base bits drop out.
   wire hit = bus_req.valid && bus_req.mem_space == window_in_memory && (window_in_memory ?
      bus_req.addr[19:8] == window_base[19:8] : bus_req.addr[15:8] == window_base[15:8]);
   logic [15:0] last_wd;
   always_ff @(posedge core_clk)
   begin
      last_wd <= bus_req.wdata;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence reloc_rd_s; hit && !bus_req.write && off == 8'hfe; endsequence
   sequence reloc_wr_s; hit && bus_req.write && off == 8'hfe; endsequence
   window_hit_a: assert property (bus_req.valid |=> bus_rsp.window_hit == $past(hit))
      else $error("window hit flag wrong");
   reg_ack_a: assert property (hit && known |=> bus_rsp.ack && !bus_rsp.unmapped)
      else $error("register offset not acknowledged");
   unmapped_a: assert property (hit && !known |=> bus_rsp.unmapped && !bus_rsp.ack && bus_rsp.rdata == 16'h0000)
      else $error("unimplemented offset answered wrongly");
   reloc_read_a: assert property (reloc_rd_s |=> bus_rsp.rdata ==
      {cbr_pkg::RELOC_RESET[15], intc_slave_mode, cbr_pkg::RELOC_RESET[13], window_in_memory,
      window_base[19:8]})
      else $error("relocation read value wrong");
   reloc_write_a: assert property (reloc_wr_s |=> intc_slave_mode == last_wd[14] &&
      window_in_memory == last_wd[12] && window_base == {last_wd[11:0], 8'h00})
      else $error("relocation write not applied");
   release_read_a: assert property (hit && !bus_req.write && off == 8'hf4 |=>
      bus_rsp.rdata == {RELEASE_REV, NARROW_BUS, 8'h00})
      else $error("release level read wrong");
   straps_read_a: assert property (hit && !bus_req.write && off == 8'hf6 |=> bus_rsp.rdata == captured_straps)
      else $error("strap capture read wrong");
   straps_hold_a: assert property ($past(rst_n) |=> $stable(captured_straps))
      else $error("strap capture changed after reset");
   pins_off_a: assert property (disable iff (1'b0) !rst_n |-> !muxed_bus_lines_oe)
      else $error("bus lines driven in reset");
   reset_value_a: assert property (disable iff (1'b0) !rst_n |->
      window_base == 20'h0ff00 && !window_in_memory && !intc_slave_mode)
      else $error("relocation reset value wrong");
endmodule
bind cbr_top cbr_top_checker #(.NARROW_BUS(NARROW_BUS), .RELEASE_REV(RELEASE_REV)) u_cbr_top_checker (
   .core_clk, .rst_n, .bus_req, .bus_rsp, .muxed_bus_lines_oe, .intc_slave_mode, .window_in_memory,
   .window_base, .captured_straps);

// ### sim/cbr_bus_master.sv
`timescale 1ns/10ps
module cbr_bus_master (
   // Clock
   input wire logic core_clk,
   // Register bus
   output cbr_pkg::cbr_bus_req_t bus_req,
   input wire cbr_pkg::cbr_bus_rsp_t bus_rsp
);
   initial bus_req = '0;
   // The answer stands for one cycle only, one edge after the taking edge.
   task automatic xfer(input logic wr, input logic mem, input logic [19:0] a, input logic [15:0] wd,
      output cbr_pkg::cbr_bus_rsp_t rsp);
      @(negedge core_clk);
      bus_req = {1'b1, wr, mem, a, wd};
      @(negedge core_clk);
      // Internal cycles take no wait state and no external ready.
      rsp = bus_rsp;
      // Released lines show garbage, never the last value.
      bus_req = {1'b0, ~wr, ~mem, ~a, ~wd};
   endtask
endmodule

// ### sim/cbr_top_tb.sv
`timescale 1ns/10ps
module cbr_top_tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b1;
   logic [15:0] straps = 16'hc3a5;
   logic [15:0] core_ad_out = 16'h1234;
   logic core_ad_oe = 1'b1;
   logic [15:0] pin_out, captured_straps;
   logic pin_oe, intc_slave_mode, window_in_memory;
   logic [19:0] window_base;
   cbr_pkg::cbr_bus_req_t bus_req;
   cbr_pkg::cbr_bus_rsp_t bus_rsp, rsp;
   int n_fail = 0;
   int cmp_count = 0;
   int cycles = 0;
   // The strap driver is on only in reset; the upper byte differs on the muxed lines to expose a wrong source.
   wire [15:0] pins = pin_oe ? pin_out : (!rst_n ? {~straps[15:8], straps[7:0]} : ~straps);
   wire [7:0] upper = !rst_n ? straps[15:8] : ~straps[15:8];
   cbr_top #(.NARROW_BUS(1'b1), .RELEASE_REV(7'h05)) u_cbr_top (.core_clk, .rst_n, .bus_req, .bus_rsp,
      .muxed_bus_lines_in(pins), .upper_address_outputs_in(upper), .muxed_bus_lines_out(pin_out),
      .muxed_bus_lines_oe(pin_oe), .core_ad_out, .core_ad_oe, .intc_slave_mode, .window_in_memory,
      .window_base, .captured_straps);
   cbr_bus_master u_cbr_bus_master (.core_clk, .bus_req, .bus_rsp);
   initial forever #2 core_clk = ~core_clk;
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic cbr_pkg::cbr_bus_rsp_t mk(input logic h, input logic a, input logic u, input logic [15:0] d);
      return {h, a, u, d};
   endfunction
   task automatic acc(input logic wr, input logic mem, input logic [19:0] a, input logic [15:0] wd,
      input cbr_pkg::cbr_bus_rsp_t exp);
      u_cbr_bus_master.xfer(wr, mem, a, wd, rsp);
      chk(20'(rsp), 20'(exp));
   endtask
   task automatic do_reset(input logic [15:0] s);
      @(negedge core_clk);
      rst_n = 1'b0;
      straps = s;
      repeat (5) @(negedge core_clk);
      chk(20'(pin_oe), 20'h0);
      rst_n = 1'b1;
      @(negedge core_clk);
      chk(20'(pin_oe), 20'h0);
      @(negedge core_clk);
      chk(20'({pin_oe, pin_out}), 20'h11234);
   endtask
   task automatic t_reset_state();
      acc(0, 0, 20'h0fffe, 16'h0, mk(1, 1, 0, 16'h20ff));
      chk(window_base, 20'h0ff00);
      acc(0, 0, 20'h0fff4, 16'h0, mk(1, 1, 0, 16'h0b00));
      acc(0, 0, 20'h0fff6, 16'h0, mk(1, 1, 0, 16'hc3a5));
   endtask
   task automatic t_read_only();
      acc(1, 0, 20'h0fff6, 16'h0000, mk(1, 1, 0, 16'h0));
      acc(1, 0, 20'h0fff4, 16'hffff, mk(1, 1, 0, 16'h0));
      acc(0, 0, 20'h0fff6, 16'h0, mk(1, 1, 0, 16'hc3a5));
      acc(0, 0, 20'h0fff4, 16'h0, mk(1, 1, 0, 16'h0b00));
      chk(20'(captured_straps), 20'h0c3a5);
   endtask
   task automatic t_decode();
      acc(0, 0, 20'h0fff0, 16'h0, mk(1, 0, 1, 16'h0));
      acc(0, 0, 20'h0fff5, 16'h0, mk(1, 0, 1, 16'h0));
      acc(0, 0, 20'hafffe, 16'h0, mk(1, 1, 0, 16'h20ff));
      acc(0, 1, 20'h0fffe, 16'h0, mk(0, 0, 0, 16'h0));
      acc(0, 0, 20'h0fefe, 16'h0, mk(0, 0, 0, 16'h0));
   endtask
   task automatic t_relocate();
      acc(1, 0, 20'h0fffe, 16'hff12, mk(1, 1, 0, 16'h0));
      chk(window_base, 20'hf1200);
      chk({18'h0, intc_slave_mode, window_in_memory}, 20'h3);
      acc(0, 1, 20'hf12fe, 16'h0, mk(1, 1, 0, 16'h7f12));
      acc(0, 0, 20'h0fffe, 16'h0, mk(0, 0, 0, 16'h0));
      acc(1, 1, 20'hf12fe, 16'h2034, mk(1, 1, 0, 16'h0));
      acc(0, 0, 20'h034fe, 16'h0, mk(1, 1, 0, 16'h2034));
      acc(0, 0, 20'h034f6, 16'h0, mk(1, 1, 0, 16'hc3a5));
   endtask
   task automatic t_second_reset();
      do_reset(16'h5a3c);
      acc(0, 0, 20'h0fffe, 16'h0, mk(1, 1, 0, 16'h20ff));
      acc(0, 0, 20'h0fff6, 16'h0, mk(1, 1, 0, 16'h5a3c));
   endtask
   initial
   begin
      #1 rst_n = 1'b0;
      do_reset(16'hc3a5);
      t_reset_state();
      t_read_only();
      t_decode();
      t_relocate();
      t_second_reset();
      give_verdict();
   end
endmodule
